// file: regx_cfg.svh
`ifndef REGX_CFG_SVH
`define REGX_CFG_SVH
`define REG_COUNT          64
`define AREA_TYPE_LO       6'h08
`define AREA_TYPE_HI       6'h0F
`define AREA_MAKER_LO      6'h10
`define AREA_MAKER_HI      6'h1E
`define AREA_USER_LO       6'h20
`define AREA_USER_HI       6'h2F
`define REG_RAW_CODE       6'h05
`define REG_DIAG           6'h06
`define REG_FUNC_CMD       6'h07
`define REG_KIND_ID        6'h08
`define REG_FW_VERSION     6'h09
`define REG_SHIFT_LEN      6'h0A
`define REG_CHAN_COUNT     6'h0B
`define REG_MIN_XFER       6'h0C
`define REG_DATA_ORG       6'h0D
`define REG_ALIGN          6'h0F
`define REG_HW_VERSION     6'h10
`define REG_OFFSET_TRIM    6'h11
`define REG_GAIN_TRIM      6'h12
`define REG_MAKER_OFFSET   6'h13
`define REG_MAKER_GAIN     6'h14
`define REG_UNLOCK         6'h1F
`define REG_FEATURES       6'h20
`define UNLOCK_VALUE       16'h1235
`define FEATURES_RESET     16'h0006
`define MAKER_GAIN_RESET   16'h0100
`define FEAT_USER_BIT      0
`define FEAT_MAKER_BIT     1
`define CTL_REG_BIT        7
`define CTL_WR_BIT         6
`define FW_VERSION_ASCII   16'h3130
`define MIN_XFER_VALUE     16'h0202
`define DATA_ORG_VALUE     16'h0004
`define SHIFT_LEN_VALUE    16'h0018
`define CHAN_COUNT_VALUE   16'h0001
`define FRAC_BITS          8
`define CODE_BITS          12
`endif

// file: regx_pkg.sv
package regx_pkg;
  typedef logic [5:0]  reg_index_t;
  typedef logic [15:0] word_t;
  typedef struct packed {
    logic       reg_mode;
    logic       write_not_read;
    reg_index_t register_index_field;
  } control_byte_s;
  typedef enum logic [1:0] {
    HOST_IDLE,
    HOST_SEND,
    HOST_WAIT
  } host_state_e;
endpackage

// file: regx_link_if.sv
`timescale 1ns/1ps
interface regx_link_if;
  // controller to terminal: control byte, then two data bytes
  logic [7:0] ctrl_byte;
  logic [7:0] out_data_lo;
  logic [7:0] out_data_hi;
  logic       out_valid;
  // terminal to controller: status byte, then two data bytes
  logic [7:0] status_byte;
  logic [7:0] in_data_lo;
  logic [7:0] in_data_hi;
  modport terminal (input ctrl_byte, out_data_lo, out_data_hi, out_valid,
                    output status_byte, in_data_lo, in_data_hi);
  modport controller (output ctrl_byte, out_data_lo, out_data_hi, out_valid,
                      input status_byte, in_data_lo, in_data_hi);
endinterface

// file: regx_scaler.sv
`timescale 1ns/1ps
`include "regx_cfg.svh"
// straight line offset + gain*x, gain fixed point with 8 fraction bits, saturating
module regx_scaler (
  // operands
  input  wire logic signed [15:0] x_in,
  input  wire logic signed [15:0] offset_in,
  input  wire logic        [15:0] gain_in,
  input  wire logic               signed_gain_in,
  // result
  output logic signed      [15:0] y_out
);
  logic signed [33:0] prod;
  logic signed [33:0] sum;
  always_comb begin
    if (signed_gain_in) begin
      prod = 34'(x_in * $signed(gain_in));
    end else begin
      prod = 34'(x_in * $signed({1'b0, gain_in}));
    end
    sum = (prod >>> `FRAC_BITS) + 34'(offset_in);
    if (sum > 34'sh0_0000_7FFF) begin
      y_out = 16'sh7FFF;
    end else if (sum < -34'sh0_0000_8000) begin
      y_out = -16'sh8000;
    end else begin
      y_out = sum[15:0];
    end
  end
endmodule

// file: regx_terminal.sv
`timescale 1ns/1ps
`include "regx_cfg.svh"
module regx_terminal #(
  parameter logic [15:0] KIND_ID = 16'h0ABC // arbitrary identity value
) (
  // clock and reset
  input  wire logic             sys_clk_in,
  input  wire logic             rst_n_in,
  // link to controller
  regx_link_if.terminal         link,
  // analog side
  output logic [11:0]           dac_code_out,
  output logic [7:0]            offset_pot_out,
  output logic [7:0]            gain_pot_out,
  output logic                  pot_load_out,
  // parameter store image, loaded after reset
  input  wire logic             nv_load_in,
  input  wire logic [16*32-1:0] nv_image_in,
  output logic [16*32-1:0]      nv_image_out
);
  // --------------------------------------------------------------
  // register storage
  // --------------------------------------------------------------
  // param_r holds 16..47; nonvolatile copy is mirrored out to a store
  logic [15:0] param_r [16:47];
  logic [15:0] param_nxt [16:47];
  logic [15:0] cmd_r, cmd_nxt;
  logic [15:0] align_r, align_nxt;
  logic        unlocked_r, unlocked_nxt;
  logic [7:0]  status_r, status_nxt;
  logic [15:0] rd_r, rd_nxt;
  logic [11:0] dac_r, dac_nxt;
  logic        pot_load_r, pot_load_nxt;
  logic        nv_pending_r, nv_pending_nxt;

  regx_pkg::control_byte_s ctl;
  regx_pkg::word_t         wdata;
  regx_pkg::word_t         rdata;
  logic                    wr_ok;
  logic signed [15:0]      y_maker, y_user, y_sel;

  assign ctl   = regx_pkg::control_byte_s'(link.ctrl_byte);
  assign wdata = {link.out_data_hi, link.out_data_lo};

  // --------------------------------------------------------------
  // scaling path
  // --------------------------------------------------------------
  regx_scaler u_maker (
    .x_in           ($signed(wdata)),
    .offset_in      ($signed(param_r[`REG_MAKER_OFFSET])),
    .gain_in        (param_r[`REG_MAKER_GAIN]),
    .signed_gain_in (1'b0),
    .y_out          (y_maker)
  );
  regx_scaler u_user (
    .x_in           (param_r[`REG_FEATURES][`FEAT_MAKER_BIT] ? y_maker : $signed(wdata)),
    .offset_in      ($signed(param_r[`REG_FEATURES + 6'h01])),
    .gain_in        (param_r[`REG_FEATURES + 6'h02]),
    .signed_gain_in (1'b1),
    .y_out          (y_user)
  );

  always_comb begin
    if (param_r[`REG_FEATURES][`FEAT_USER_BIT]) begin
      y_sel = y_user;
    end else if (param_r[`REG_FEATURES][`FEAT_MAKER_BIT]) begin
      y_sel = y_maker;
    end else begin
      y_sel = $signed(wdata);
    end
  end

  // --------------------------------------------------------------
  // read mux
  // --------------------------------------------------------------
  always_comb begin
    rdata = 16'h0000;
    case (ctl.register_index_field)
      `REG_RAW_CODE:   rdata = {4'h0, dac_r};
      `REG_DIAG:       rdata = 16'h0000;
      `REG_FUNC_CMD:   rdata = cmd_r;
      `REG_KIND_ID:    rdata = KIND_ID;
      `REG_FW_VERSION: rdata = `FW_VERSION_ASCII;
      `REG_SHIFT_LEN:  rdata = `SHIFT_LEN_VALUE;
      `REG_CHAN_COUNT: rdata = `CHAN_COUNT_VALUE;
      `REG_MIN_XFER:   rdata = `MIN_XFER_VALUE;
      `REG_DATA_ORG:   rdata = `DATA_ORG_VALUE;
      `REG_ALIGN:      rdata = align_r;
      `REG_UNLOCK:     rdata = unlocked_r ? `UNLOCK_VALUE : 16'h0000;
      default: begin
        if (ctl.register_index_field >= `AREA_MAKER_LO && ctl.register_index_field <= `AREA_USER_HI) begin
          rdata = param_r[ctl.register_index_field];
        end
      end
    endcase
  end

  // --------------------------------------------------------------
  // access engine
  // --------------------------------------------------------------
  // protection covers maker area and user area except the code word itself
  assign wr_ok = unlocked_r;

  always_comb begin
    param_nxt      = param_r;
    cmd_nxt        = cmd_r;
    align_nxt      = align_r;
    unlocked_nxt   = unlocked_r;
    status_nxt     = status_r;
    rd_nxt         = rd_r;
    dac_nxt        = dac_r;
    pot_load_nxt   = 1'b0;
    nv_pending_nxt = nv_pending_r;
    if (nv_pending_r && nv_load_in) begin
      for (int i = 16; i < 48; i++) begin
        param_nxt[i] = nv_image_in[(i-16)*16 +: 16];
      end
      nv_pending_nxt = 1'b0;
      pot_load_nxt   = 1'b1;
    end else if (link.out_valid) begin
      if (!ctl.reg_mode) begin
        status_nxt = 8'h00;
        dac_nxt    = y_sel[15:4] ^ 12'h800;
      end else if (!ctl.write_not_read) begin
        status_nxt = {1'b1, 1'b0, ctl.register_index_field};
        rd_nxt     = rdata;
      end else begin
        status_nxt = {1'b1, 1'b1, ctl.register_index_field};
        rd_nxt     = 16'h0000;
        case (ctl.register_index_field)
          `REG_FUNC_CMD: cmd_nxt = {8'h00, wdata[7:0]};
          `REG_ALIGN:    align_nxt = wdata;
          `REG_UNLOCK:   unlocked_nxt = (wdata == `UNLOCK_VALUE);
          default: begin
            if (ctl.register_index_field >= `AREA_MAKER_LO && ctl.register_index_field <= `AREA_USER_HI
                && wr_ok) begin
              param_nxt[ctl.register_index_field] = wdata;
              if (ctl.register_index_field == `REG_OFFSET_TRIM ||
                  ctl.register_index_field == `REG_GAIN_TRIM) begin
                pot_load_nxt = 1'b1;
              end
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 16; i < 48; i++) begin
        param_r[i] <= 16'h0000;
      end
      param_r[`REG_MAKER_GAIN] <= `MAKER_GAIN_RESET;
      param_r[`REG_FEATURES]   <= `FEATURES_RESET;
      cmd_r        <= 16'h0000;
      align_r      <= 16'h0000;
      unlocked_r   <= 1'b0;
      status_r     <= 8'h00;
      rd_r         <= 16'h0000;
      dac_r        <= 12'h800;
      pot_load_r   <= 1'b1;
      nv_pending_r <= 1'b1;
    end else begin
      param_r      <= param_nxt;
      cmd_r        <= cmd_nxt;
      align_r      <= align_nxt;
      unlocked_r   <= unlocked_nxt;
      status_r     <= status_nxt;
      rd_r         <= rd_nxt;
      dac_r        <= dac_nxt;
      pot_load_r   <= pot_load_nxt;
      nv_pending_r <= nv_pending_nxt;
    end
  end

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  assign link.status_byte = status_r;
  assign link.in_data_lo  = rd_r[7:0];
  assign link.in_data_hi  = rd_r[15:8];
  assign dac_code_out     = dac_r;
  assign offset_pot_out   = param_r[`REG_OFFSET_TRIM][7:0];
  assign gain_pot_out     = param_r[`REG_GAIN_TRIM][7:0];
  assign pot_load_out     = pot_load_r;
  always_comb begin
    for (int i = 16; i < 48; i++) begin
      nv_image_out[(i-16)*16 +: 16] = param_r[i];
    end
  end
endmodule

// file: regx_controller.sv
`timescale 1ns/1ps
`include "regx_cfg.svh"
module regx_controller (
  // clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  // user request
  input  wire logic        req_in,
  input  wire logic        req_write_in,
  input  wire logic [5:0]  req_index_in,
  input  wire logic [15:0] req_data_in,
  input  wire logic [15:0] process_data_in,
  output logic             busy_out,
  output logic             done_out,
  output logic [15:0]      rd_data_out,
  // link to terminal
  regx_link_if.controller  link
);
  regx_pkg::host_state_e state_r, state_nxt;
  logic [7:0]  ctl_r, ctl_nxt;
  logic [15:0] data_r, data_nxt;
  logic [15:0] rd_r, rd_nxt;
  logic        done_r, done_nxt;

  always_comb begin
    state_nxt = state_r;
    ctl_nxt   = ctl_r;
    data_nxt  = data_r;
    rd_nxt    = rd_r;
    done_nxt  = 1'b0;
    case (state_r)
      regx_pkg::HOST_IDLE: begin
        ctl_nxt  = 8'h00;
        data_nxt = process_data_in;
        if (req_in) begin
          ctl_nxt   = {1'b1, req_write_in, req_index_in};
          data_nxt  = req_write_in ? req_data_in : 16'h0000;
          state_nxt = regx_pkg::HOST_SEND;
        end
      end
      regx_pkg::HOST_SEND: state_nxt = regx_pkg::HOST_WAIT;
      regx_pkg::HOST_WAIT: begin
        if (link.status_byte == ctl_r) begin
          rd_nxt    = {link.in_data_hi, link.in_data_lo};
          done_nxt  = 1'b1;
          state_nxt = regx_pkg::HOST_IDLE;
        end
      end
      default: state_nxt = regx_pkg::HOST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= regx_pkg::HOST_IDLE;
      ctl_r   <= 8'h00;
      data_r  <= 16'h0000;
      rd_r    <= 16'h0000;
      done_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ctl_r   <= ctl_nxt;
      data_r  <= data_nxt;
      rd_r    <= rd_nxt;
      done_r  <= done_nxt;
    end
  end

  assign link.ctrl_byte   = ctl_r;
  assign link.out_data_lo = data_r[7:0];
  assign link.out_data_hi = data_r[15:8];
  assign link.out_valid   = 1'b1;
  assign busy_out         = (state_r != regx_pkg::HOST_IDLE);
  assign done_out         = done_r;
  assign rd_data_out      = rd_r;
endmodule

// file: terminal_channel_register_access_assertions.sv
`timescale 1ns/1ps
`include "regx_cfg.svh"
module terminal_channel_register_access_assertions #(
  parameter logic [15:0] KIND_ID = 16'h0ABC // arbitrary identity value
) (
  // clock, reset and parameter load
  input wire logic       sys_clk_in,
  input wire logic       rst_n_in,
  input wire logic       nv_load_in,
  // controller to terminal
  input wire logic [7:0] ctrl_byte,
  input wire logic [7:0] out_data_lo,
  input wire logic [7:0] out_data_hi,
  input wire logic       out_valid,
  // terminal to controller
  input wire logic [7:0] status_byte,
  input wire logic [7:0] in_data_lo,
  input wire logic [7:0] in_data_hi
);
  // ------------------------------------------------------------
  // shadow of the write protection
  // ------------------------------------------------------------
  logic        open_r;
  logic        open_nxt;
  logic        rd;
  logic        wr;
  logic [15:0] word_in;
  assign rd = out_valid && nv_load_in && ctrl_byte[7:6] == 2'b10;
  assign wr = out_valid && nv_load_in && ctrl_byte[7:6] == 2'b11;
  assign word_in = {in_data_hi, in_data_lo};
  always_comb begin
    open_nxt = open_r;
    if (wr && ctrl_byte[5:0] == `REG_UNLOCK) begin
      open_nxt = ({out_data_hi, out_data_lo} == `UNLOCK_VALUE);
    end
  end
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      open_r <= 1'b0;
    end else begin
      open_r <= open_nxt;
    end
  end
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in || !nv_load_in);
  chk_read_echo: assert property (rd |=> status_byte == $past(ctrl_byte))
    else $error("read status differs from control byte");
  chk_write_ack: assert property (wr |=> status_byte[7] && status_byte[5:0] == $past(ctrl_byte[5:0]))
    else $error("write acknowledge wrong");
  chk_code_word: assert property (rd && ctrl_byte[5:0] == `REG_UNLOCK
    |=> word_in == ($past(open_r) ? `UNLOCK_VALUE : 16'h0000))
    else $error("code word readback wrong");
  chk_kind_fixed: assert property (rd && ctrl_byte[5:0] == `REG_KIND_ID |=> word_in == KIND_ID)
    else $error("kind register changed");
  chk_fw_ascii: assert property (rd && ctrl_byte[5:0] == `REG_FW_VERSION |=> word_in == `FW_VERSION_ASCII)
    else $error("firmware version wrong");
  chk_min_xfer: assert property (rd && ctrl_byte[5:0] == `REG_MIN_XFER |=> word_in == `MIN_XFER_VALUE)
    else $error("minimum length wrong");
  chk_data_org: assert property (rd && ctrl_byte[5:0] == `REG_DATA_ORG |=> word_in == `DATA_ORG_VALUE)
    else $error("data type code wrong");
  chk_read_stable: assert property (rd && $stable(ctrl_byte) && ctrl_byte[5:3] != 3'b000 |=> $stable(word_in))
    else $error("repeated read changed value");
  chk_ext_zero: assert property (rd && ctrl_byte[5:4] == 2'b11 |=> word_in == 16'h0000)
    else $error("extended area not zero");
  cover property (wr && ctrl_byte[5:0] == `REG_UNLOCK && {out_data_hi, out_data_lo} == `UNLOCK_VALUE);
  cover property (wr && !open_r && ctrl_byte[5:4] == 2'b01);
  cover property (rd ##1 rd);
endmodule

// file: tb_terminal_channel_register_access.sv
`timescale 1ns/1ps
`include "regx_cfg.svh"
module tb_terminal_channel_register_access;
  localparam logic [15:0] KIND_ID = 16'h0A5C; // arbitrary identity value
  logic           sys_clk_in, rst_n_in, req_in, req_write_in, busy_out, done_out;
  logic           nv_load_in, pot_load_out;
  logic [5:0]     req_index_in;
  logic [15:0]    req_data_in, process_data_in, rd_data_out, v, x;
  logic [11:0]    dac_code_out;
  logic [7:0]     offset_pot_out, gain_pot_out;
  logic [511:0]   nv_image_in, nv_image_out;
  int             seed, fail_count, checks_done, i;
  regx_link_if link_inst();
  regx_terminal #(.KIND_ID(KIND_ID)) regx_terminal_inst (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .link(link_inst), .dac_code_out(dac_code_out), .offset_pot_out(offset_pot_out),
    .gain_pot_out(gain_pot_out), .pot_load_out(pot_load_out), .nv_load_in(nv_load_in),
    .nv_image_in(nv_image_in), .nv_image_out(nv_image_out));
  regx_controller regx_controller_inst (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .req_in(req_in),
    .req_write_in(req_write_in), .req_index_in(req_index_in), .req_data_in(req_data_in),
    .process_data_in(process_data_in), .busy_out(busy_out), .done_out(done_out),
    .rd_data_out(rd_data_out), .link(link_inst));
  terminal_channel_register_access_assertions #(.KIND_ID(KIND_ID)) chk_inst (.sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in), .nv_load_in(nv_load_in), .ctrl_byte(link_inst.ctrl_byte),
    .out_data_lo(link_inst.out_data_lo), .out_data_hi(link_inst.out_data_hi),
    .out_valid(link_inst.out_valid), .status_byte(link_inst.status_byte),
    .in_data_lo(link_inst.in_data_lo), .in_data_hi(link_inst.in_data_hi));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic wr, input logic [5:0] idx, input logic [15:0] data);
    int n;
    @(negedge sys_clk_in);
    req_in = 1'b1;
    req_write_in = wr;
    req_index_in = idx;
    req_data_in = data;
    @(negedge sys_clk_in);
    check({15'h0000, busy_out}, 16'h0001);
    req_in = 1'b0;
    n = 0;
    while (done_out !== 1'b1 && n < 20) begin
      @(negedge sys_clk_in);
      n++;
    end
    check({15'h0000, done_out}, 16'h0001);
  endtask
  task automatic rd(input logic [5:0] idx, input logic [15:0] exp);
    xfer(1'b0, idx, 16'h0000);
    check(rd_data_out, exp);
  endtask
  // scaled word with unit gain, shown offset binary on the converter
  function automatic logic [15:0] exp_dac(input logic [15:0] d, input logic [15:0] off);
    logic [15:0] y;
    y = d + off;
    return {4'h0, y[15:4] ^ 12'h800};
  endfunction
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // stimulus
  // ------------------------------------------------------------
  initial begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end
  initial begin
    repeat (20000) @(posedge sys_clk_in);
    fail_count++;
    report_and_stop();
  end
  initial begin
    seed = 34;
    fail_count = 0;
    checks_done = 0;
    {req_in, req_write_in, req_index_in, req_data_in, process_data_in, nv_load_in} = '0;
    for (i = 0; i < 32; i++) begin
      nv_image_in[i*16 +: 16] = $random(seed);
    end
    nv_image_in[3*16 +: 16] = 16'h0000; // maker offset starts at zero
    nv_image_in[4*16 +: 16] = `MAKER_GAIN_RESET;
    nv_image_in[16*16 +: 16] = 16'h0002; // maker scaling only
    rst_n_in = 1'b0;
    repeat (10) @(negedge sys_clk_in);
    rst_n_in = 1'b1;
    @(negedge sys_clk_in);
    nv_load_in = 1'b1;
    repeat (4) @(negedge sys_clk_in);
    check({8'h00, offset_pot_out}, {8'h00, nv_image_in[23:16]});
    check({8'h00, gain_pot_out}, {8'h00, nv_image_in[39:32]});
    rd(`REG_KIND_ID, KIND_ID);
    rd(`REG_FW_VERSION, `FW_VERSION_ASCII);
    rd(`REG_MIN_XFER, `MIN_XFER_VALUE);
    rd(`REG_DATA_ORG, `DATA_ORG_VALUE);
    rd(`REG_MAKER_OFFSET, 16'h0000);
    rd(`REG_UNLOCK, 16'h0000);
    v = $random(seed);
    xfer(1'b1, `REG_KIND_ID, v);
    rd(`REG_KIND_ID, KIND_ID);
    xfer(1'b1, `REG_MAKER_OFFSET, v);
    rd(`REG_MAKER_OFFSET, 16'h0000);
    $display("test locked done");
    xfer(1'b1, `REG_UNLOCK, `UNLOCK_VALUE);
    rd(`REG_UNLOCK, `UNLOCK_VALUE);
    for (i = 1; i < 3; i++) begin
      v = $random(seed);
      xfer(1'b1, `REG_HW_VERSION + 6'(i), v);
      check({15'h0000, pot_load_out}, 16'h0001);
      rd(`REG_HW_VERSION + 6'(i), v);
      check(nv_image_out[i*16 +: 16], v);
      check({8'h00, (i == 1) ? offset_pot_out : gain_pot_out}, {8'h00, v[7:0]});
    end
    for (i = 0; i < 8; i++) begin
      v = $random(seed);
      xfer(1'b1, `REG_FUNC_CMD, v);
      rd(`REG_FUNC_CMD, {8'h00, v[7:0]});
      rd(6'h30 | 6'(v[3:0]), 16'h0000);
    end
    x = $random(seed) & 16'h0FFF;
    xfer(1'b1, `REG_MAKER_OFFSET, 16'h0100);
    process_data_in = x;
    repeat (6) @(negedge sys_clk_in);
    check({4'h0, dac_code_out}, exp_dac(x, 16'h0100));
    xfer(1'b1, `REG_FEATURES, 16'h0000);
    repeat (6) @(negedge sys_clk_in);
    check({4'h0, dac_code_out}, exp_dac(x, 16'h0000));
    rd(`REG_RAW_CODE, exp_dac(x, 16'h0000));
    $display("test unlocked done");
    v = $random(seed);
    xfer(1'b1, `REG_UNLOCK, (v == `UNLOCK_VALUE) ? 16'h0000 : v);
    rd(`REG_UNLOCK, 16'h0000);
    v = $random(seed);
    xfer(1'b1, `REG_MAKER_OFFSET, v);
    rd(`REG_MAKER_OFFSET, 16'h0100);
    $display("test relock done");
    report_and_stop();
  end
endmodule
